// File: verilog/dcp_pkg.sv
// Shared constants and types for the disk controller processor port
package dcp_pkg;

   // Data path widths and buffer count
   localparam int DCP_DATA_W  = 32;
   localparam int DCP_UINST_W = 6;
   localparam int DCP_ADDR_W  = 9;
   localparam int DCP_BYTE_W  = 8;
   localparam int DCP_NUM_BUF = 2;

   // Last buffer address for the small-sector and large-sector drive types
   localparam logic [DCP_ADDR_W-1:0] DCP_SMALL_LAST = 9'h0ff;
   localparam logic [DCP_ADDR_W-1:0] DCP_LARGE_LAST = 9'h1ff;

   // Byte steps taken by one byte write and one longword write
   localparam logic [2:0] DCP_STEPS_BYTE = 3'h1;
   localparam logic [2:0] DCP_STEPS_WORD = 3'h4;

   // Values after reset
   localparam logic [DCP_DATA_W-1:0] DCP_CSR_RST = 32'h0000_0000;
   localparam logic [DCP_DATA_W-1:0] DCP_DAR_RST = 32'h0000_0000;

   // Buffer indices
   localparam int DCP_BUF_A = 0;
   localparam int DCP_BUF_B = 1;

   // Port microinstruction codes
   typedef enum logic [DCP_UINST_W-1:0] {
      DCP_UI_NOP       = 6'h00,
      DCP_UI_WRITE_CSR = 6'h01,
      DCP_UI_WRITE_DAR = 6'h02,
      DCP_UI_READ_CSR  = 6'h03,
      DCP_UI_READ_DAR  = 6'h04,
      DCP_UI_READ_POS  = 6'h05,
      DCP_UI_READ_PAT  = 6'h06,
      DCP_UI_SEL_BUF_A = 6'h07,
      DCP_UI_SEL_BUF_B = 6'h08,
      DCP_UI_CLR_CNTR  = 6'h09,
      DCP_UI_WR_BYTE   = 6'h0a,
      DCP_UI_WR_WORD   = 6'h0b,
      DCP_UI_INIT      = 6'h0c,
      DCP_UI_CLR_IRQ   = 6'h0d
   } dcp_uinst_t;

   // Armed read selection
   typedef enum logic [2:0] {
      DCP_RS_NONE = 3'b000,
      DCP_RS_CSR  = 3'b001,
      DCP_RS_DAR  = 3'b010,
      DCP_RS_POS  = 3'b011,
      DCP_RS_PAT  = 3'b100
   } dcp_rsel_t;

endpackage

// File: verilog/dcp_buf_if.sv
// Control bundle between the port logic and one buffer address counter
`timescale 1ns/1ps
`default_nettype none
interface dcp_buf_if #(parameter int AW = 9);
   logic          host_sel;
   logic          host_clr;
   logic          host_step;
   logic          seq_sel;
   logic          seq_clr;
   logic          seq_inc;
   logic          seq_wr;
   logic          large_sector;
   logic [AW-1:0] addr;
   logic          wr_en;
   logic          at_last;

   modport ctr  (input host_sel, host_clr, host_step, seq_sel, seq_clr, seq_inc, seq_wr,
                 large_sector, output addr, wr_en, at_last);
   modport port (output host_sel, host_clr, host_step, seq_sel, seq_clr, seq_inc, seq_wr,
                 large_sector, input addr, wr_en, at_last);
endinterface
`default_nettype wire

// File: verilog/dcp_buf_ctr.sv
// Address counter and write control of one sector buffer
`timescale 1ns/1ps
`default_nettype none
module dcp_buf_ctr
   import dcp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   dcp_buf_if.ctr   b
);

   logic [DCP_ADDR_W-1:0] addr_r;
   logic                  clr;
   logic                  inc;

   // Either owner may clear or step, but only through its own select
   assign clr = (b.host_clr & b.host_sel) | (b.seq_clr & b.seq_sel);
   assign inc = (b.host_step & b.host_sel) | (b.seq_inc & b.seq_sel);

   // Clear has priority so a fresh sector always starts at zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         addr_r <= '0;
      else if (clr)
         addr_r <= '0;
      else if (inc)
         addr_r <= addr_r + 9'h001;
   end

   assign b.addr    = addr_r;
   assign b.wr_en   = (b.host_step & b.host_sel) | (b.seq_wr & b.seq_sel);
   assign b.at_last = (addr_r == (b.large_sector ? DCP_LARGE_LAST : DCP_SMALL_LAST));

endmodule
`default_nettype wire

// File: verilog/dcp_port.sv
// Processor port of the disk controller: decode, register load, read-back, buffer fill
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Decoded control-register write pulses a strobe; register loads the bus word then.
// - Decoded disk-address write pulses a strobe; disk address register loads the word.
// - Read-type microinstructions are armed into a read select register during phase 2.
// - Read strobe is honoured only while accelerator select is low.
// - Armed control-register read drives its select and the read-out enable.
// - Armed disk-address read drives its select and the read-out enable.
// - Armed error position or pattern read drives that select and read-out enable.
// - Select-A sets the host buffer-A select; counter-clear pulses to both counters.
// - Buffer B has identical counter and control logic with its own select.
// - Each counter is driven by both host port and sequencer.
// - Port timing follows phase-2 and port clock pins; derived phase-2 clock output.
// - Microinstructions initialise controller and drive, and clear the level-5 request.
// - A longword write stores four bytes in consecutive buffer locations.
module dcp_port
   import dcp_pkg::*;
#(
   parameter int DW = DCP_DATA_W
)
(
   input  wire logic                                 clk,
   input  wire logic                                 arst_n,
   input  wire logic                                 proc_phase2,
   input  wire logic                                 port_clock,
   input  wire logic                                 port_instruction_strobe,
   input  wire logic [DCP_UINST_W-1:0]               port_uinst,
   input  wire logic                                 read_port_n,
   input  wire logic                                 accelerator_select,
   input  wire logic [DW-1:0]                        y_bus_in,
   output var  logic [DW-1:0]                        y_bus_out,
   output var  logic                                 y_bus_oe,
   input  wire logic [DW-1:0]                        ecc_position,
   input  wire logic [DW-1:0]                        ecc_pattern,
   input  wire logic                                 large_sector,
   input  wire logic [DCP_NUM_BUF-1:0]               seq_sel,
   input  wire logic                                 seq_clr,
   input  wire logic                                 seq_inc,
   input  wire logic                                 seq_write,
   input  wire logic [DCP_BYTE_W-1:0]                seq_wdata,
   input  wire logic                                 irq_event,
   output var  logic                                 derived_phase2_clock_n,
   output var  logic                                 ctrl_reg_write_strobe,
   output var  logic                                 disk_addr_write_strobe,
   output var  logic [DW-1:0]                        ctrl_reg_q,
   output var  logic [DW-1:0]                        disk_address_reg,
   output var  logic                                 ctrl_reg_read_select,
   output var  logic                                 disk_addr_read_select,
   output var  logic                                 ecc_pos_read_select,
   output var  logic                                 ecc_pat_read_select,
   output var  logic                                 readout_enable,
   output var  logic [DCP_NUM_BUF-1:0]               host_buf_sel,
   output var  logic                                 host_counter_clear,
   output var  logic [DCP_NUM_BUF-1:0][DCP_ADDR_W-1:0] buf_addr,
   output var  logic [DCP_NUM_BUF-1:0]               buf_write,
   output var  logic [DCP_NUM_BUF-1:0][DCP_BYTE_W-1:0] buf_wdata,
   output var  logic [DCP_NUM_BUF-1:0]               buf_at_last,
   output var  logic                                 ctrl_init,
   output var  logic                                 drive_init,
   output var  logic                                 bus_request_level5
);

   localparam int PW = DW + DCP_UINST_W + 5;

   // Pin synchroniser stages; only the second stage is read by logic
   logic [PW-1:0]          pin_s1_r;
   logic [PW-1:0]          pin_s2_r;
   logic                   ph2_d_r;
   logic                   pclk_d_r;
   logic                   ph2_s;
   logic                   pclk_s;
   logic                   instr_s;
   logic                   rd_n_s;
   logic                   acc_s;
   logic [DCP_UINST_W-1:0] uinst_s;
   logic [DW-1:0]          ybus_s;
   dcp_uinst_t             uinst;
   logic                   wr_evt;
   logic                   rd_evt;
   logic                   rd_q;
   dcp_rsel_t              rsel_r;
   logic [2:0]             step_r;
   logic [1:0]             lane_r;
   logic [DW-1:0]          word_r;
   logic                   host_step;
   logic [DCP_BYTE_W-1:0]  host_byte;

   // Every processor port pin crosses into clk through two flops; the Y bus is held
   // steady by the processor for the whole microcycle, so per-bit skew settles
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else
      begin
         pin_s1_r <= {proc_phase2, port_clock, port_instruction_strobe, read_port_n,
                      accelerator_select, port_uinst, y_bus_in};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign {ph2_s, pclk_s, instr_s, rd_n_s, acc_s, uinst_s, ybus_s} = pin_s2_r;
   assign uinst = dcp_uinst_t'(uinst_s);

   // Edge history for the two processor timing pins
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ph2_d_r  <= 1'b0;
         pclk_d_r <= 1'b0;
      end
      else
      begin
         ph2_d_r  <= ph2_s;
         pclk_d_r <= pclk_s;
      end
   end

   // Write-type work is taken on the port clock rise, read arming on phase 2
   assign wr_evt = pclk_s & ~pclk_d_r & instr_s;
   assign rd_evt = ph2_s & ~ph2_d_r & instr_s;

   // Derived phase-2 clock, low while phase 2 is active
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         derived_phase2_clock_n <= 1'b1;
      else
         derived_phase2_clock_n <= ~ph2_s;
   end

   // Register write strobes and the registers they load, on the same edge
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg_write_strobe  <= 1'b0;
         disk_addr_write_strobe <= 1'b0;
         ctrl_reg_q             <= DCP_CSR_RST;
         disk_address_reg       <= DCP_DAR_RST;
      end
      else
      begin
         ctrl_reg_write_strobe  <= wr_evt && (uinst == DCP_UI_WRITE_CSR);
         disk_addr_write_strobe <= wr_evt && (uinst == DCP_UI_WRITE_DAR);
         if (wr_evt && (uinst == DCP_UI_WRITE_CSR))
            ctrl_reg_q <= ybus_s;
         if (wr_evt && (uinst == DCP_UI_WRITE_DAR))
            disk_address_reg <= ybus_s;
      end
   end

   // Read select register: stays armed so repeated strobes reread the same source
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rsel_r <= DCP_RS_NONE;
      else if (rd_evt)
      begin
         case (uinst)
            DCP_UI_READ_CSR: rsel_r <= DCP_RS_CSR;
            DCP_UI_READ_DAR: rsel_r <= DCP_RS_DAR;
            DCP_UI_READ_POS: rsel_r <= DCP_RS_POS;
            DCP_UI_READ_PAT: rsel_r <= DCP_RS_PAT;
            default:         rsel_r <= rsel_r;
         endcase
      end
   end

   // A strobe counts only when it is ours: read strobe low and accelerator select low
   assign rd_q = ~rd_n_s & ~acc_s;

   // Read-back selects, read-out enable and Y bus drive
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg_read_select  <= 1'b0;
         disk_addr_read_select <= 1'b0;
         ecc_pos_read_select   <= 1'b0;
         ecc_pat_read_select   <= 1'b0;
         readout_enable        <= 1'b0;
         y_bus_oe              <= 1'b0;
         y_bus_out             <= '0;
      end
      else
      begin
         ctrl_reg_read_select  <= rd_q && (rsel_r == DCP_RS_CSR);
         disk_addr_read_select <= rd_q && (rsel_r == DCP_RS_DAR);
         ecc_pos_read_select   <= rd_q && (rsel_r == DCP_RS_POS);
         ecc_pat_read_select   <= rd_q && (rsel_r == DCP_RS_PAT);
         readout_enable        <= rd_q && (rsel_r != DCP_RS_NONE);
         y_bus_oe              <= rd_q && (rsel_r != DCP_RS_NONE);
         case (rsel_r)
            DCP_RS_CSR: y_bus_out <= ctrl_reg_q;
            DCP_RS_DAR: y_bus_out <= disk_address_reg;
            DCP_RS_POS: y_bus_out <= ecc_position;
            DCP_RS_PAT: y_bus_out <= ecc_pattern;
            default:    y_bus_out <= '0;
         endcase
      end
   end

   // Host buffer select is exclusive; counter clear is a one-cycle pulse
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         host_buf_sel       <= '0;
         host_counter_clear <= 1'b0;
      end
      else
      begin
         host_counter_clear <= wr_evt && (uinst == DCP_UI_CLR_CNTR);
         if (wr_evt && (uinst == DCP_UI_SEL_BUF_A))
            host_buf_sel <= 2'b01;
         else if (wr_evt && (uinst == DCP_UI_SEL_BUF_B))
            host_buf_sel <= 2'b10;
      end
   end

   // Byte stepper: one byte per clk, lane 0 first; a microcycle spans far more
   // clks than four, so a new write never lands on a busy stepper in practice
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         step_r <= 3'h0;
         lane_r <= 2'h0;
         word_r <= '0;
      end
      else if (wr_evt && (uinst == DCP_UI_WR_BYTE))
      begin
         step_r <= DCP_STEPS_BYTE;
         lane_r <= 2'h0;
         word_r <= ybus_s;
      end
      else if (wr_evt && (uinst == DCP_UI_WR_WORD))
      begin
         step_r <= DCP_STEPS_WORD;
         lane_r <= 2'h0;
         word_r <= ybus_s;
      end
      else if (step_r != 3'h0)
      begin
         step_r <= step_r - 3'h1;
         lane_r <= lane_r + 2'h1;
      end
   end

   assign host_step = (step_r != 3'h0);
   assign host_byte = word_r[lane_r*DCP_BYTE_W +: DCP_BYTE_W];

   // One counter per buffer, each under host and sequencer control
   generate
      for (genvar i = 0; i < DCP_NUM_BUF; i++)
      begin : g_buf
         dcp_buf_if #(.AW(DCP_ADDR_W)) bus ();

         assign bus.host_sel     = host_buf_sel[i];
         assign bus.host_clr     = host_counter_clear;
         assign bus.host_step    = host_step;
         assign bus.seq_sel      = seq_sel[i];
         assign bus.seq_clr      = seq_clr;
         assign bus.seq_inc      = seq_inc;
         assign bus.seq_wr       = seq_write;
         assign bus.large_sector = large_sector;

         dcp_buf_ctr u_ctr (
            .clk    (clk),
            .arst_n (arst_n),
            .b      (bus.ctr)
         );

         // Address, strobe and data leave together from one set of flops
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               buf_addr[i]    <= '0;
               buf_write[i]   <= 1'b0;
               buf_wdata[i]   <= '0;
               buf_at_last[i] <= 1'b0;
            end
            else
            begin
               buf_addr[i]    <= bus.addr;
               buf_write[i]   <= bus.wr_en;
               buf_wdata[i]   <= (host_step && host_buf_sel[i]) ? host_byte : seq_wdata;
               buf_at_last[i] <= bus.at_last;
            end
         end
      end
   endgenerate

   // Initialisation pulses and the level-5 request; a new event beats a clear
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_init          <= 1'b0;
         drive_init         <= 1'b0;
         bus_request_level5 <= 1'b0;
      end
      else
      begin
         ctrl_init  <= wr_evt && (uinst == DCP_UI_INIT);
         drive_init <= wr_evt && (uinst == DCP_UI_INIT);
         if (irq_event)
            bus_request_level5 <= 1'b1;
         else if (wr_evt && (uinst == DCP_UI_CLR_IRQ))
            bus_request_level5 <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// File: tb/dcp_port_monitor.sv
// Concurrent checks on the processor port pins of the disk controller
`timescale 1ns/1ps
`default_nettype none
module dcp_port_monitor
   import dcp_pkg::*;
(
   input wire logic                                   clk,
   input wire logic                                   arst_n,
   input wire logic                                   proc_phase2,
   input wire logic                                   read_port_n,
   input wire logic                                   accelerator_select,
   input wire logic [DCP_DATA_W-1:0]                  y_bus_in,
   input wire logic [DCP_DATA_W-1:0]                  y_bus_out,
   input wire logic                                   y_bus_oe,
   input wire logic                                   irq_event,
   input wire logic                                   derived_phase2_clock_n,
   input wire logic                                   ctrl_reg_write_strobe,
   input wire logic                                   disk_addr_write_strobe,
   input wire logic [DCP_DATA_W-1:0]                  ctrl_reg_q,
   input wire logic [DCP_DATA_W-1:0]                  disk_address_reg,
   input wire logic                                   ctrl_reg_read_select,
   input wire logic                                   disk_addr_read_select,
   input wire logic                                   ecc_pos_read_select,
   input wire logic                                   ecc_pat_read_select,
   input wire logic                                   readout_enable,
   input wire logic [DCP_NUM_BUF-1:0]                 host_buf_sel,
   input wire logic                                   host_counter_clear,
   input wire logic [DCP_NUM_BUF-1:0][DCP_ADDR_W-1:0] buf_addr,
   input wire logic [DCP_NUM_BUF-1:0]                 buf_write,
   input wire logic                                   bus_request_level5
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Two back-to-back byte writes into buffer A form one run
   sequence s_run_a;
      buf_write[0] ##1 buf_write[0];
   endsequence

   a_csr_load_word: assert property (ctrl_reg_write_strobe |-> ctrl_reg_q == y_bus_in)
      else $error("control register did not take the bus word");
   a_csr_strobe_pulse: assert property (ctrl_reg_write_strobe |=> !ctrl_reg_write_strobe)
      else $error("control register strobe longer than one cycle");
   a_dar_load_word: assert property (disk_addr_write_strobe
      |-> disk_address_reg == y_bus_in)
      else $error("disk address register did not take the bus word");
   a_read_needs_strobe: assert property (readout_enable |->
      $past(!read_port_n, 3) && $past(!accelerator_select, 3))
      else $error("read-out enable without a qualified read strobe");
   a_one_source: assert property (readout_enable |-> y_bus_oe && $onehot({
      ctrl_reg_read_select, disk_addr_read_select, ecc_pos_read_select, ecc_pat_read_select}))
      else $error("read-out without exactly one register select");
   a_select_drives: assert property ((ctrl_reg_read_select || disk_addr_read_select ||
      ecc_pos_read_select || ecc_pat_read_select) |-> readout_enable)
      else $error("register select without read-out enable");
   a_csr_readback: assert property (ctrl_reg_read_select && y_bus_oe
      |-> y_bus_out == ctrl_reg_q)
      else $error("wrong control register value on the bus");
   a_dar_readback: assert property (disk_addr_read_select && y_bus_oe
      |-> y_bus_out == disk_address_reg)
      else $error("wrong disk address value on the bus");
   a_clear_pulse: assert property (host_counter_clear |=> !host_counter_clear)
      else $error("counter clear longer than one cycle");
   a_buf_sel_excl: assert property ($onehot0(host_buf_sel))
      else $error("both host buffer selects set");
   a_byte_step: assert property (s_run_a |-> buf_addr[0] == $past(buf_addr[0]) + 9'h001)
      else $error("buffer address did not advance by one");
   a_irq_set: assert property (irq_event |=> bus_request_level5)
      else $error("interrupt request not raised");
   a_phase2_follow: assert property (proc_phase2 [*5] |-> !derived_phase2_clock_n)
      else $error("derived phase-2 clock does not follow the pin");
endmodule
bind dcp_port dcp_port_monitor i_dcp_port_monitor (.clk, .arst_n, .proc_phase2, .read_port_n,
   .accelerator_select, .y_bus_in, .y_bus_out, .y_bus_oe, .irq_event, .derived_phase2_clock_n,
   .ctrl_reg_write_strobe, .disk_addr_write_strobe, .ctrl_reg_q, .disk_address_reg,
   .ctrl_reg_read_select, .disk_addr_read_select, .ecc_pos_read_select, .ecc_pat_read_select,
   .readout_enable, .host_buf_sel, .host_counter_clear, .buf_addr, .buf_write,
   .bus_request_level5);
`default_nettype wire

// File: tb/dcp_proc_model.sv
// Behavioural processor microcode engine driving the port pins
`timescale 1ns/1ps
`default_nettype none
module dcp_proc_model
   import dcp_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic [DCP_DATA_W-1:0] y_bus_out,
   input  wire logic                  y_bus_oe,
   output var  logic                  port_clock,
   output var  logic                  proc_phase2,
   output var  logic                  port_instruction_strobe,
   output var  logic [DCP_UINST_W-1:0] port_uinst,
   output var  logic                  read_port_n,
   output var  logic                  accelerator_select,
   output var  logic [DCP_DATA_W-1:0] y_bus_in
);
   initial
   begin
      port_clock = 1'b0;
      proc_phase2 = 1'b0;
      port_instruction_strobe = 1'b0;
      port_uinst = DCP_UI_NOP;
      read_port_n = 1'b1;
      accelerator_select = 1'b0;
      y_bus_in = 32'h0000_0000;
   end

   // One microinstruction; pins held past the synchroniser lag
   task automatic issue(input logic [DCP_UINST_W-1:0] code, input logic [DCP_DATA_W-1:0] data);
      @(negedge clk);
      port_uinst = code;
      port_instruction_strobe = 1'b1;
      y_bus_in = data;
      repeat (4) @(negedge clk);
      port_clock = 1'b1;
      proc_phase2 = 1'b1;
      repeat (9) @(negedge clk);
      port_clock = 1'b0;
      proc_phase2 = 1'b0;
      repeat (4) @(negedge clk);
      port_instruction_strobe = 1'b0;
      // Released bus shows the inverse of the data
      y_bus_in = ~data;
   endtask

   // Read strobe in a later microcycle than the arming instruction
   task automatic rd(input logic acc, output logic [DCP_DATA_W-1:0] q, output logic oe);
      @(negedge clk);
      accelerator_select = acc;
      read_port_n = 1'b0;
      repeat (5) @(negedge clk);
      q = y_bus_out;
      oe = y_bus_oe;
      read_port_n = 1'b1;
      repeat (5) @(negedge clk);
      accelerator_select = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the disk controller processor port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dcp_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic pclk, ph2, pis, rdn, acc, oe, roe, irq = 1'b0, sclr = 1'b0, sinc = 1'b0, swr = 1'b0;
   logic [DCP_UINST_W-1:0] ui;
   logic [31:0] yin, yout, creg, dreg, q;
   logic [31:0] pos = 32'h0bad_f00d, pat = 32'h5a5a_a5a5;
   logic [1:0] ssel = 2'b00;
   logic [7:0] swd = 8'h00;
   logic [1:0] hsel, bwr, last;
   logic [1:0][8:0] badr;
   logic [1:0][7:0] bwd;
   logic cinit, dinit, irqo;
   logic [17:0] logq [2][$];
   int n_mismatch = 0;
   int n_compared = 0;
   int n_init = 0, cyc = 0;

   always #2 clk = ~clk;

   dcp_proc_model i_dcp_proc_model (.clk, .y_bus_out(yout), .y_bus_oe(oe), .port_clock(pclk),
      .proc_phase2(ph2), .port_instruction_strobe(pis), .port_uinst(ui), .read_port_n(rdn),
      .accelerator_select(acc), .y_bus_in(yin));

   dcp_port i_dcp_port (.clk, .arst_n, .proc_phase2(ph2), .port_clock(pclk),
      .port_instruction_strobe(pis), .port_uinst(ui), .read_port_n(rdn),
      .accelerator_select(acc), .y_bus_in(yin), .y_bus_out(yout), .y_bus_oe(oe),
      .ecc_position(pos), .ecc_pattern(pat), .large_sector(1'b0), .seq_sel(ssel),
      .seq_clr(sclr), .seq_inc(sinc), .seq_write(swr), .seq_wdata(swd), .irq_event(irq),
      .derived_phase2_clock_n(), .ctrl_reg_write_strobe(), .disk_addr_write_strobe(),
      .ctrl_reg_q(creg), .disk_address_reg(dreg), .ctrl_reg_read_select(),
      .disk_addr_read_select(), .ecc_pos_read_select(), .ecc_pat_read_select(),
      .readout_enable(), .host_buf_sel(hsel), .host_counter_clear(), .buf_addr(badr),
      .buf_write(bwr), .buf_wdata(bwd), .buf_at_last(last), .ctrl_init(cinit),
      .drive_init(dinit), .bus_request_level5(irqo));

   // Log every byte landing in either buffer; timeout guards a hang
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cinit === 1'b1 && dinit === 1'b1) n_init <= n_init + 1;
      for (int b = 0; b < 2; b++)
         if (bwr[b] === 1'b1) logq[b].push_back({last[b], badr[b], bwd[b]});
      if (cyc == 8000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Check one logged byte of a buffer
   task automatic chk_log(input int b, input int k, input logic [8:0] a, input logic [7:0] d);
      chk("log byte", {14'h0, a == DCP_SMALL_LAST, a, d}, (k < logq[b].size()) ? logq[b][k] : 'x);
   endtask

   task automatic t_unarmed();
      i_dcp_proc_model.rd(1'b0, q, roe);
      chk("oe unarmed", 32'h0, roe);
   endtask

   task automatic t_write_regs();
      i_dcp_proc_model.issue(DCP_UI_WRITE_CSR, 32'h1234_5678);
      chk("control register", 32'h1234_5678, creg);
      i_dcp_proc_model.issue(DCP_UI_WRITE_DAR, 32'h9abc_def0);
      chk("disk address register", 32'h9abc_def0, dreg);
      chk("control register kept", 32'h1234_5678, creg);
   endtask

   // Each read code refused under accelerator select, then honoured
   task automatic t_reads();
      logic [5:0] codes [4];
      logic [31:0] exp [4];
      codes = '{DCP_UI_READ_CSR, DCP_UI_READ_DAR, DCP_UI_READ_POS, DCP_UI_READ_PAT};
      exp = '{32'h1234_5678, 32'h9abc_def0, 32'h0bad_f00d, 32'h5a5a_a5a5};
      for (int i = 0; i < 4; i++)
      begin
         i_dcp_proc_model.issue(codes[i], 32'h0);
         i_dcp_proc_model.rd(1'b1, q, roe);
         chk("oe with accelerator", 32'h0, roe);
         i_dcp_proc_model.rd(1'b0, q, roe);
         chk("oe on read", 32'h1, roe);
         chk("read word", exp[i], q);
      end
   endtask

   // Small sector into buffer A as longwords, byte k holding k
   task automatic t_fill_a();
      i_dcp_proc_model.issue(DCP_UI_SEL_BUF_A, 32'h0);
      chk("host select A", 32'h1, hsel);
      i_dcp_proc_model.issue(DCP_UI_CLR_CNTR, 32'h0);
      logq[0].delete();
      for (int w = 0; w < 64; w++)
         i_dcp_proc_model.issue(DCP_UI_WR_WORD, {8'(4*w+3), 8'(4*w+2), 8'(4*w+1), 8'(4*w)});
      chk("bytes in A", 32'd256, logq[0].size());
      for (int k = 0; k < 256; k++)
         chk_log(0, k, 9'(k), 8'(k));
   endtask

   // Buffer B: byte, clear, then word restarts at zero
   task automatic t_buf_b();
      i_dcp_proc_model.issue(DCP_UI_SEL_BUF_B, 32'h0);
      chk("host select B", 32'h2, hsel);
      i_dcp_proc_model.issue(DCP_UI_CLR_CNTR, 32'h0);
      logq[1].delete();
      i_dcp_proc_model.issue(DCP_UI_WR_BYTE, 32'hffff_ff77);
      i_dcp_proc_model.issue(DCP_UI_CLR_CNTR, 32'h0);
      i_dcp_proc_model.issue(DCP_UI_WR_WORD, 32'h4433_2211);
      chk("bytes in B", 32'd5, logq[1].size());
      chk_log(1, 0, 9'h000, 8'h77);
      for (int k = 0; k < 4; k++)
         chk_log(1, k + 1, 9'(k), 8'(8'h11 * (k + 1)));
   endtask

   // Sequencer writes buffer A while the host holds B
   task automatic t_seq();
      logq[0].delete();
      @(negedge clk);
      ssel = 2'b01;
      sclr = 1'b1;
      @(negedge clk);
      sclr = 1'b0;
      swr = 1'b1;
      sinc = 1'b1;
      swd = 8'hc3;
      @(negedge clk);
      swr = 1'b0;
      sinc = 1'b0;
      repeat (4) @(negedge clk);
      chk("sequencer bytes", 32'd1, logq[0].size());
      chk_log(0, 0, 9'h000, 8'hc3);
   endtask

   task automatic t_irq_init();
      @(negedge clk);
      irq = 1'b1;
      @(negedge clk);
      irq = 1'b0;
      repeat (2) @(negedge clk);
      chk("irq raised", 32'h1, irqo);
      i_dcp_proc_model.issue(DCP_UI_CLR_IRQ, 32'h0);
      chk("irq cleared", 32'h0, irqo);
      i_dcp_proc_model.issue(DCP_UI_INIT, 32'h0);
      chk("init pulses", 32'd1, n_init);
   endtask

   initial
   begin
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_unarmed();
      t_write_regs();
      t_reads();
      t_fill_a();
      t_buf_b();
      t_seq();
      t_irq_init();
      report_and_stop();
   end
endmodule
`default_nettype wire
